/* File: design/smf_framer.sv */
`timescale 1ns/100ps
`include "smf_params.svh"

module smf_framer
   import smf_pkg::*;
(
   input  wire logic          I_MCLK,
   input  wire logic          I_RST_N,
   input  wire logic          I_CE,
   input  wire logic          I_VALID,
   input  wire logic [15:0]   I_SAMPLE,
   input  wire logic [7:0]    I_MODE_QUAD,
   input  wire logic [3:0]    I_RATE_IDX,
   output logic               O_VALID,
   output smf_sample_s        O_SAMPLE,
   output logic               O_FRAME_STB,
   output smf_mode_e          O_FRAME_MODE,
   output logic               O_BUDGET_STB,
   output smf_budget_s        O_BUDGET,
   output logic               O_MODE_ERR
);

   // ==========================================================
   // decoding helpers

   // grouping check on a quadruplet, m0 in the low bits
   function automatic logic quad_legal(input logic [7:0] q);
      logic lo_ok;
      logic hi_ok;
      logic all_full;
      lo_ok    = (!q[1] && !q[3]) || (q[1:0] == SMF_DOUBLE &&
                  q[3:2] == SMF_DOUBLE);
      hi_ok    = (!q[5] && !q[7]) || (q[5:4] == SMF_DOUBLE &&
                  q[7:6] == SMF_DOUBLE);
      all_full = (q == {SMF_FULL, SMF_FULL, SMF_FULL, SMF_FULL});
      quad_legal = (lo_ok && hi_ok) || all_full; // R5
   endfunction

   // mode of frame f within quadruplet q
   function automatic smf_mode_e mode_of(input logic [7:0] q,
                                         input logic [1:0] f);
      mode_of = smf_mode_e'(q[{f, 1'b0} +: 2]);
   endfunction

   // ==========================================================
   // state
   smf_state_e   state;
   smf_state_e   next_state;
   logic [9:0]   pos;
   logic [9:0]   next_pos;
   logic [7:0]   quad;
   logic [7:0]   next_quad;
   logic [7:0]   la_cnt;
   logic [7:0]   next_la_cnt;
   logic         ovalid;
   logic         next_ovalid;
   smf_sample_s  osample;
   smf_sample_s  next_osample;
   logic         fstb;
   logic         next_fstb;
   smf_mode_e    fmode;
   smf_mode_e    next_fmode;
   logic         bstb;
   logic         next_bstb;
   smf_budget_s  budget;
   smf_budget_s  next_budget;
   logic         err;
   logic         next_err;

   // ==========================================================
   // next-value logic: every accepted sample advances one position
   always_comb begin
      logic [7:0] cur_quad;
      logic [1:0] f;
      logic [7:0] q;
      smf_mode_e  m;
      logic       first;
      logic       last;
      cur_quad     = quad;
      f            = pos[9:8];
      q            = pos[7:0];
      m            = SMF_PRED;
      first        = 1'b0;
      last         = 1'b0;
      next_state   = state;
      next_pos     = pos;
      next_quad    = quad;
      next_la_cnt  = la_cnt;
      next_ovalid  = 1'b0;
      next_osample = osample;
      next_fstb    = 1'b0;
      next_fmode   = fmode;
      next_bstb    = 1'b0;
      next_budget  = budget;
      next_err     = 1'b0;
      if (I_VALID) begin
         // the quadruplet is sampled with the first sample of a superframe
         if (state == SMF_ST_START) begin
            // an illegal set is replaced by all-predictive so the
            // downstream encoders never see a broken grouping
            if (quad_legal(I_MODE_QUAD)) begin
               cur_quad = I_MODE_QUAD;
            end else begin
               cur_quad = `SMF_QUAD_RST;
               next_err = 1'b1; // R11
            end
            next_quad  = cur_quad;
            next_state = SMF_ST_BODY;
         end
         m = mode_of(cur_quad, f); // R2
         // block edges follow the mode's grouping
         case (m)
            SMF_DOUBLE: begin
               first = !f[0] && q == `SMF_FRM_FIRST; // R4
               last  = f[0] && q == `SMF_FRM_LAST; // R4
            end
            SMF_FULL: begin
               first = pos == `SMF_POS_FIRST; // R6
               last  = pos == `SMF_POS_LAST; // R6
            end
            default: begin
               first = q == `SMF_FRM_FIRST;
               last  = q == `SMF_FRM_LAST;
            end
         endcase
         next_ovalid            = 1'b1;
         next_osample.data      = I_SAMPLE;
         next_osample.frame     = f;
         next_osample.mode      = m; // R10
         next_osample.blk_first = first;
         next_osample.blk_last  = last;
         next_osample.to_pred   = m == SMF_PRED; // R7
         next_osample.to_xform  = m != SMF_PRED;
         // samples still inside the tail of the previous transform block
         next_osample.lookahead = la_cnt != `SMF_LA_NONE;
         if (la_cnt != `SMF_LA_NONE) begin
            next_la_cnt = la_cnt - 8'h01;
         end
         // a finished transform block opens its look-ahead window
         if (last) begin
            case (m)
               SMF_SHORT:  next_la_cnt = `SMF_LA_SHORT; // R3
               SMF_DOUBLE: next_la_cnt = `SMF_LA_DOUBLE; // R4
               SMF_FULL:   next_la_cnt = `SMF_LA_FULL; // R6
               default:    next_la_cnt = next_la_cnt;
            endcase
         end
         // per-frame mode announcement
         if (q == `SMF_FRM_FIRST) begin
            next_fstb  = 1'b1;
            next_fmode = m; // R10
         end
         // stereo budget for long windows, given at the block start
         if (first && m == SMF_DOUBLE) begin
            next_bstb                = 1'b1;
            next_budget.total        = `SMF_ST512_BASE +
                                       {2'h0, I_RATE_IDX, 4'h0}; // R8
            next_budget.mode_bits    = `SMF_ST512_MODE; // R8
            next_budget.unused_bits  = `SMF_ST512_UNUSED; // R8
            next_budget.gain_bits    = `SMF_ST_GAIN;
            next_budget.hf_isf_bits  = `SMF_ST_HF_ISF;
            next_budget.hf_gain_bits = `SMF_ST_HF_GAIN;
            next_budget.full         = 1'b0;
         end else if (first && m == SMF_FULL) begin
            next_bstb                = 1'b1;
            next_budget.total        = `SMF_ST1024_BASE +
                                       {1'h0, I_RATE_IDX, 5'h00}; // R9
            next_budget.mode_bits    = `SMF_ST1024_MODE; // R9
            next_budget.unused_bits  = `SMF_ST1024_UNUSED; // R9
            next_budget.gain_bits    = `SMF_ST_GAIN;
            next_budget.hf_isf_bits  = `SMF_ST_HF_ISF;
            next_budget.hf_gain_bits = `SMF_ST_HF_GAIN;
            next_budget.full         = 1'b1;
         end
         // 10-bit position wraps exactly after 1024 samples
         next_pos = pos + 10'h001; // R1
         if (pos == `SMF_POS_LAST) begin
            next_state = SMF_ST_START; // R1
         end
      end
   end

   // ==========================================================
   // registers; a low clock enable freezes everything, pulses included
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state   <= SMF_ST_START;
         pos     <= `SMF_POS_FIRST;
         quad    <= `SMF_QUAD_RST;
         la_cnt  <= `SMF_LA_NONE;
         ovalid  <= 1'b0;
         osample <= '0;
         fstb    <= 1'b0;
         fmode   <= SMF_PRED;
         bstb    <= 1'b0;
         budget  <= '0;
         err     <= 1'b0;
      end else if (I_CE) begin
         state   <= next_state;
         pos     <= next_pos;
         quad    <= next_quad;
         la_cnt  <= next_la_cnt;
         ovalid  <= next_ovalid;
         osample <= next_osample;
         fstb    <= next_fstb;
         fmode   <= next_fmode;
         bstb    <= next_bstb;
         budget  <= next_budget;
         err     <= next_err;
      end
   end

   // ==========================================================
   // outputs, all registered
   assign O_VALID      = ovalid;
   assign O_SAMPLE     = osample;
   assign O_FRAME_STB  = fstb;
   assign O_FRAME_MODE = fmode;
   assign O_BUDGET_STB = bstb;
   assign O_BUDGET     = budget;
   assign O_MODE_ERR   = err;

endmodule

/* File: design/smf_params.svh */
// Operation
// (R1) one mono half-rate sample stream is grouped into 1024-sample superframes
// (R2) four 256-sample frames each get exactly one of four coding modes
// (R3) short transform frames go out as 256 samples plus 32 look-ahead
// (R4) double transform joins two frames into 512 samples plus 64 look-ahead
// (R5) double transform is legal only on frames 0-1 or frames 2-3
// (R6) full transform codes all four frames as 1024 samples plus 128 look-ahead
// (R7) predictive frames route their 256 samples to the speech encoder
// (R8) 512 stereo packet: fixed fields, total 80 to 320 bits, 16-bit steps
// (R9) 1024 stereo packet: fixed fields, total 160 to 640 bits
// (R10) every frame carries its own two-bit mode code
// (R11) a quadruplet breaking the grouping rules raises an error
`ifndef SMF_PARAMS_SVH
`define SMF_PARAMS_SVH

// ==========================================================
// stream geometry
`define SMF_SAMPLE_W      16
`define SMF_POS_LAST      10'h3FF
`define SMF_POS_FIRST     10'h000
`define SMF_FRM_LAST      8'hFF
`define SMF_FRM_FIRST     8'h00

// ==========================================================
// look-ahead lengths in samples
`define SMF_LA_SHORT      8'h20
`define SMF_LA_DOUBLE     8'h40
`define SMF_LA_FULL       8'h80
`define SMF_LA_NONE       8'h00

// ==========================================================
// stereo packet budgets
`define SMF_ST512_BASE    10'h050
`define SMF_ST1024_BASE   10'h0A0
`define SMF_ST512_MODE    3'h4
`define SMF_ST1024_MODE   3'h6
`define SMF_ST512_UNUSED  2'h2
`define SMF_ST1024_UNUSED 2'h3
`define SMF_ST_GAIN       4'h7
`define SMF_ST_HF_ISF     4'h9
`define SMF_ST_HF_GAIN    4'h7

// ==========================================================
// reset values
`define SMF_QUAD_RST      8'h00

`endif

/* File: design/smf_pkg.sv */
package smf_pkg;

   // ==========================================================
   // per-frame coding mode, values are the transmitted codes
   typedef enum logic [1:0] {
      SMF_PRED   = 2'h0,
      SMF_SHORT  = 2'h1,
      SMF_DOUBLE = 2'h2,
      SMF_FULL   = 2'h3
   } smf_mode_e;

   // superframe phase, gray path start -> body -> start
   typedef enum logic [1:0] {
      SMF_ST_START = 2'h0,
      SMF_ST_BODY  = 2'h1
   } smf_state_e;

   // ==========================================================
   // one tagged output sample
   typedef struct packed {
      logic [15:0] data;
      logic [1:0]  frame;
      smf_mode_e   mode;
      logic        blk_first;
      logic        blk_last;
      logic        to_pred;
      logic        to_xform;
      logic        lookahead;
   } smf_sample_s;

   // stereo packet budget for one transform window
   typedef struct packed {
      logic [9:0] total;
      logic [2:0] mode_bits;
      logic [1:0] unused_bits;
      logic [3:0] gain_bits;
      logic [3:0] hf_isf_bits;
      logic [3:0] hf_gain_bits;
      logic       full;
   } smf_budget_s;

endpackage

/* File: verification/smf_framer_chk.sv */
`timescale 1ns/100ps
module smf_framer_chk
   import smf_pkg::*;
(
   input wire logic        I_MCLK,
   input wire logic        I_RST_N,
   input wire logic        I_CE,
   input wire logic        I_VALID,
   input wire logic [15:0] I_SAMPLE,
   input wire logic        O_VALID,
   input wire smf_sample_s O_SAMPLE,
   input wire logic        O_FRAME_STB,
   input wire smf_mode_e   O_FRAME_MODE,
   input wire logic        O_BUDGET_STB,
   input wire smf_budget_s O_BUDGET,
   input wire logic        O_MODE_ERR
);
   // ==========================================================
   // one clock domain, so clocking and reset are given once
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);

   property p_take;
      I_VALID && I_CE |=> O_VALID && O_SAMPLE.data == $past(I_SAMPLE);
   endproperty
   a_take: assert property (p_take) else $error("sample lost");
   property p_gap;
      !I_VALID && I_CE |=> !O_VALID;
   endproperty
   a_gap: assert property (p_gap) else $error("spurious output");
   property p_stb;
      O_FRAME_STB |-> O_VALID && O_FRAME_MODE == O_SAMPLE.mode;
   endproperty
   a_stb: assert property (p_stb) else $error("frame code off");
   property p_pair;
      O_VALID && O_SAMPLE.blk_first && O_SAMPLE.mode == SMF_DOUBLE
         |-> !O_SAMPLE.frame[0];
   endproperty
   a_pair: assert property (p_pair) else $error("double pair off");
   property p_full;
      O_VALID && O_SAMPLE.blk_first && O_SAMPLE.mode == SMF_FULL
         |-> O_SAMPLE.frame == 2'h0;
   endproperty
   a_full: assert property (p_full) else $error("full block start");
   property p_route;
      O_VALID |-> O_SAMPLE.to_pred == (O_SAMPLE.mode == SMF_PRED)
         && O_SAMPLE.to_xform != O_SAMPLE.to_pred;
   endproperty
   a_route: assert property (p_route) else $error("routing off");
   property p_b512;
      O_BUDGET_STB && !O_BUDGET.full |-> O_BUDGET.total[3:0] == 4'h0
         && O_BUDGET.total inside {[10'h050:10'h140]}
         && O_BUDGET.mode_bits == 3'h4 && O_BUDGET.unused_bits == 2'h2;
   endproperty
   a_b512: assert property (p_b512) else $error("512 budget off");
   property p_b1024;
      O_BUDGET_STB && O_BUDGET.full |-> O_BUDGET.total[4:0] == 5'h00
         && O_BUDGET.total inside {[10'h0A0:10'h280]}
         && O_BUDGET.mode_bits == 3'h6 && O_BUDGET.unused_bits == 2'h3;
   endproperty
   a_b1024: assert property (p_b1024) else $error("1024 budget off");
   property p_err;
      O_MODE_ERR |-> O_VALID && O_SAMPLE.frame == 2'h0
         && O_SAMPLE.mode == SMF_PRED;
   endproperty
   a_err: assert property (p_err) else $error("bad quad kept");
   property p_hold;
      !I_CE |=> $stable(O_VALID) && $stable(O_SAMPLE)
         && $stable(O_FRAME_STB) && $stable(O_BUDGET_STB);
   endproperty
   a_hold: assert property (p_hold) else $error("freeze broken");
endmodule

bind smf_framer smf_framer_chk u_chk (.I_MCLK, .I_RST_N, .I_CE, .I_VALID,
   .I_SAMPLE, .O_VALID, .O_SAMPLE, .O_FRAME_STB, .O_FRAME_MODE,
   .O_BUDGET_STB, .O_BUDGET, .O_MODE_ERR);

/* File: verification/smf_framer_tb.sv */
`timescale 1ns/100ps
module smf_framer_tb;
   import smf_pkg::*;
   logic mclk = 0, rst_n = 0, start = 0, gap = 0, valid, busy;
   logic [7:0] quad = 8'h00;
   logic [3:0] idx = 4'h0;
   logic [15:0] sample;
   logic o_valid, o_fstb, o_bstb, o_err;
   smf_sample_s o_smp;
   smf_mode_e o_fmode;
   smf_budget_s o_bud, bud;
   logic ce = 1'b1, cegap = 1'b0, ce_seen = 1'b1, prev_v;
   smf_sample_s prev_s;
   int cyc = 0, n_last;
   int miscompares = 0, n_checks = 0, n_la, n_pred, n_err, n_f3, n_bstb;
   // ==========================================================
   // 20 MHz clock
   always #25 mclk = ~mclk;
   // clock enable: with cegap set every third edge is frozen
   always @(posedge mclk) begin
      ce_seen = ce;
      cyc++;
      #1 ce = !(cegap && cyc % 3 == 0);
   end
   smf_framer DUT (.I_MCLK(mclk), .I_RST_N(rst_n), .I_CE(ce),
      .I_VALID(valid), .I_SAMPLE(sample), .I_MODE_QUAD(quad),
      .I_RATE_IDX(idx), .O_VALID(o_valid), .O_SAMPLE(o_smp),
      .O_FRAME_STB(o_fstb), .O_FRAME_MODE(o_fmode), .O_BUDGET_STB(o_bstb),
      .O_BUDGET(o_bud), .O_MODE_ERR(o_err));
   smf_src u_src (.i_clk(mclk), .i_ce(ce), .i_start(start), .i_gap(gap),
      .o_valid(valid), .o_sample(sample), .o_busy(busy));
   // tally settled outputs at the falling edge; a frozen cycle must
   // repeat the previous outputs and is not counted again
   always @(negedge mclk) begin
      if (ce_seen !== 1'b1) begin
         chk("hold_valid", o_valid, prev_v);
         chk("hold_sample", o_smp, prev_s);
      end else begin
         if (o_valid === 1'b1) begin
            n_la += (o_smp.lookahead === 1'b1);
            n_pred += (o_smp.to_pred === 1'b1);
            n_last += (o_smp.blk_last === 1'b1);
         end
         n_err += (o_err === 1'b1);
         n_f3 += (o_fstb === 1'b1 && o_fmode === SMF_FULL);
         n_bstb += (o_bstb === 1'b1);
         if (o_bstb === 1'b1) bud = o_bud;
      end
      prev_v = o_valid;
      prev_s = o_smp;
   end
   // ==========================================================
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s exp %0d got %0d", nm, exp, got);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one superframe; quad held throughout since only its first is read
   task automatic run_sf(input logic [7:0] q, input logic [3:0] r,
                         input logic g);
      int i;
      // change inputs just after an edge, never on it
      @(posedge mclk);
      #1;
      n_la = 0;
      n_last = 0;
      n_pred = 0;
      n_err = 0;
      n_f3 = 0;
      n_bstb = 0;
      quad = q;
      idx = r;
      gap = g;
      start = 1'b1;
      @(posedge mclk);
      #1 start = 1'b0;
      for (i = 0; i < 2200; i++) begin
         @(posedge mclk);
         #2;
         if (busy === 1'b0) break;
      end
      if (i == 2200) begin
         miscompares++;
         final_report();
      end
      repeat (3) @(posedge mclk);
   endtask
   // ==========================================================
   task automatic t_full;
      run_sf(8'hFF, 4'h2, 1'b0);
      chk("bud_total", bud.total, 32'h0E0);
      chk("bud_mode", bud.mode_bits, 32'h6);
      chk("bud_full", bud.full, 32'h1);
      chk("frm_full", n_f3, 32'h4);
      chk("bud_unused", bud.unused_bits, 32'h3);
      chk("bud_gain", bud.gain_bits, 32'h7);
      chk("bud_hf", {bud.hf_isf_bits, bud.hf_gain_bits}, 32'h97);
      chk("blk_last", n_last, 32'h1);
      run_sf(8'h00, 4'h0, 1'b1);
      chk("la_full", n_la, 32'h80);
      chk("pred_cnt", n_pred, 32'h400);
   endtask
   task automatic t_double;
      run_sf(8'h1A, 4'hF, 1'b0);
      chk("bud_total", bud.total, 32'h140);
      chk("bud_mode", bud.mode_bits, 32'h4);
      chk("bud_unused", bud.unused_bits, 32'h2);
      chk("la_mixed", n_la, 32'h60);
      chk("bud_stb", n_bstb, 32'h1);
      chk("pred_frm", n_pred, 32'h100);
      chk("blk_last", n_last, 32'h3);
      chk("bud_fix", {bud.gain_bits, bud.hf_isf_bits, bud.hf_gain_bits},
          32'h797);
   endtask
   // frozen enable every third edge; double on the second pair
   task automatic t_hold;
      cegap = 1'b1;
      run_sf(8'hA5, 4'h3, 1'b0);
      cegap = 1'b0;
      chk("bud_total", bud.total, 32'h080);
      chk("la_short", n_la, 32'h40);
      chk("blk_last", n_last, 32'h3);
      chk("pred_none", n_pred, 32'h0);
      chk("bud_stb", n_bstb, 32'h1);
      run_sf(8'h00, 4'h0, 1'b0);
      chk("la_double", n_la, 32'h40);
   endtask
   task automatic t_illegal;
      logic [7:0] bad [2] = '{8'h06, 8'h3F};
      foreach (bad[k]) begin
         run_sf(bad[k], 4'h0, 1'b0);
         chk("err", n_err, 32'h1);
         chk("pred_all", n_pred, 32'h400);
      end
   endtask
   // reset for 4 cycles, then the scenarios
   initial begin
      repeat (4) @(posedge mclk);
      #1 rst_n = 1'b1;
      t_full();
      t_double();
      t_illegal();
      t_hold();
      final_report();
   end
endmodule

/* File: verification/smf_src.sv */
`timescale 1ns/100ps
module smf_src (
   input  wire logic        i_clk,
   input  wire logic        i_ce,
   input  wire logic        i_start,
   input  wire logic        i_gap,
   output logic             o_valid,
   output logic [15:0]      o_sample,
   output logic             o_busy
);
   int   left = 0;
   logic odd  = 1'b0;
   logic go;
   logic en;
   initial begin
      o_valid = 1'b0;
      o_sample = 16'h0000;
      o_busy = 1'b0;
   end
   // upstream stage: one superframe of samples; idle data is scrambled
   always @(posedge i_clk) begin
      go = i_start;
      en = i_ce;
      #1;
      if (go) begin
         left = 1024;
         o_busy = 1'b1;
      end
      // a sample not taken because the enable was low is held
      if (en) begin
         if (left > 0 && !(i_gap && odd)) begin
            o_valid = 1'b1;
            o_sample = o_sample + 16'h0001;
            left--;
         end else begin
            o_valid = 1'b0;
            o_sample = ~o_sample;
         end
         odd = ~odd;
      end
      if (left == 0) o_busy = 1'b0;
   end
endmodule
